// *** shared/apcfg_consts.svh ***
// Constants for the angle post-processing stage: field positions and codes.
// Assumes 12-bit angle words and 26-bit configuration words.
`ifndef APCFG_CONSTS_SVH
`define APCFG_CONSTS_SVH
`define APCFG_OUTCFG_OFFSET   8'h3d
`define APCFG_LIMCFG_OFFSET   8'h3c
`define APCFG_GAINCFG_OFFSET  8'h3b
`define APCFG_CFG_W           26
`define APCFG_ANG_W           12
`define APCFG_BW_BIT          25
`define APCFG_POL_BIT         24
`define APCFG_ZS_HI           23
`define APCFG_ZS_LO           12
`define APCFG_HC_HI           11
`define APCFG_HC_LO           6
`define APCFG_LC_HI           5
`define APCFG_LC_LO           0
`define APCFG_SS_BIT          25
`define APCFG_CE_BIT          25
`define APCFG_ROE_BIT         24
`define APCFG_MAXIN_HI        23
`define APCFG_MAXIN_LO        12
`define APCFG_MININ_HI        11
`define APCFG_MININ_LO        0
`define APCFG_GAIN_HI         12
`define APCFG_GAIN_LO         0
`define APCFG_MIN_OFF         12'h000
`define APCFG_MAX_OFF         12'hfff
`define APCFG_FULL_SCALE      12'hfff
`define APCFG_CLAMP_STEP      12'h029
`define APCFG_OUTCFG_RESET    26'h0000000
`endif

// *** shared/apcfg_pkg.sv ***
// Types for the angle post-processing stage.
// Assumes the constants header is included by the files that need numbers.
package apcfg_pkg;
  typedef logic [11:0] apcfg_angle_t;
  typedef logic [25:0] apcfg_cfg_t;
  typedef enum logic [1:0] {
    APCFG_MODE_NORMAL = 2'b00,
    APCFG_MODE_ROLL   = 2'b01,
    APCFG_MODE_CLAMP  = 2'b10,
    APCFG_MODE_BOTH   = 2'b11
  } apcfg_mode_t;
endpackage

// *** core/apcfg_gain.sv ***
// Gain scaling stage: multiplies an angle by 1 + gain in 5.8 form.
// Assumes a 13-bit gain word; the result saturates at full scale.
`timescale 1ns/1ps
`include "apcfg_consts.svh"
module apcfg_gain (
  // Operands.
  input  wire logic [11:0] angle_i,
  input  wire logic [12:0] gain_i,
  input  wire logic        enable_i,
  // Result.
  output logic      [11:0] scaled_o
);
  logic [26:0] prod;
  // Product of angle and (256 + gain), rescaled by 256 and saturated.
  always_comb begin
    prod = 27'(angle_i) * (27'd256 + 27'(gain_i));
    if (!enable_i) begin
      scaled_o = angle_i;
    end else if (prod[26:8] > 19'(`APCFG_FULL_SCALE)) begin
      scaled_o = `APCFG_FULL_SCALE;
    end else begin
      scaled_o = prod[19:8];
    end
  end
endmodule

// *** core/apcfg_top.sv ***
// Angle post-processing stage: polarity, pre-offset, limit checks, gain,
// output zero shift, clamps and roll-over, analog filter select.
// Assumes a new angle is presented with a one-cycle valid strobe.
// Assumes the configuration words are stable while an angle is in flight.
`timescale 1ns/1ps
`include "apcfg_consts.svh"
module apcfg_top
  import apcfg_pkg::*;
(
  // Clock and reset.
  input  wire logic                ref_clk_i,
  input  wire logic                rstn_i,
  // Configuration words.
  input  wire apcfg_pkg::apcfg_cfg_t output_shaping_config_i,
  input  wire apcfg_pkg::apcfg_cfg_t limit_config_i,
  input  wire apcfg_pkg::apcfg_cfg_t gain_config_i,
  input  wire apcfg_pkg::apcfg_angle_t pregain_offset_i,
  // Angle from the front end.
  input  wire apcfg_pkg::apcfg_angle_t raw_angle_i,
  input  wire logic                raw_valid_i,
  // Output to the driver.
  output apcfg_pkg::apcfg_angle_t  out_angle_o,
  output logic                     out_valid_o,
  output logic                     min_violation_o,
  output logic                     max_violation_o,
  output logic                     filter_bw_select_o
);
  import apcfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State.
  // The whole pipeline is combinational from the input angle to the state
  // register, so an answer always appears exactly one edge after its strobe.
  // The held fields remember the first clamp reached while clamps are on and
  // roll-over is off; they are the only state that outlives a single sample.
  typedef struct packed {
    logic [11:0] angle;
    logic        valid;
    logic        min_viol;
    logic        max_viol;
    logic        bw;
    logic        held;
    logic [11:0] held_val;
  } apcfg_state_t;

  apcfg_state_t state_reg;
  apcfg_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  // Helper: clamp level for a six-bit code, stepping about 41 counts each.
  // The product is taken wide so that code 63 cannot overflow; the largest
  // level is well below full scale, so the low twelve bits hold it exactly.
  // The same helper serves both the high and the low clamp.
  function automatic logic [11:0] clamp_level(input logic [5:0] code);
    logic [17:0] step;
    step = 18'(code) * 18'(`APCFG_CLAMP_STEP);
    return step[11:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Field decode.
  // Every field is taken straight from the configuration words, which are
  // levels; a change takes effect on the next strobe without any reload, and the filter select bit on the next edge.
  // The limit fields are compared in raw angle counts, so code 0xfff is one
  // count short of a full turn.
  logic        ss_en;
  logic        clamp_en;
  logic        roll_en;
  logic        polarity;
  logic [11:0] min_in;
  logic [11:0] max_in;
  logic [11:0] zero_shift;
  logic [11:0] high_clamp;
  logic [11:0] low_clamp;
  logic [11:0] pol_angle;
  logic [11:0] pre_angle;
  logic [11:0] scaled;
  logic [11:0] shifted;
  logic [11:0] final_angle;
  apcfg_mode_t mode;

  assign ss_en      = gain_config_i[`APCFG_SS_BIT];
  assign clamp_en   = limit_config_i[`APCFG_CE_BIT];
  assign roll_en    = limit_config_i[`APCFG_ROE_BIT];
  assign polarity   = output_shaping_config_i[`APCFG_POL_BIT];
  assign min_in     = limit_config_i[`APCFG_MININ_HI:`APCFG_MININ_LO];
  assign max_in     = limit_config_i[`APCFG_MAXIN_HI:`APCFG_MAXIN_LO];
  assign zero_shift = output_shaping_config_i[`APCFG_ZS_HI:`APCFG_ZS_LO];
  assign high_clamp = `APCFG_FULL_SCALE -
                      clamp_level(output_shaping_config_i[`APCFG_HC_HI:`APCFG_HC_LO]);
  assign low_clamp  = clamp_level(output_shaping_config_i[`APCFG_LC_HI:`APCFG_LC_LO]);
  assign mode       = apcfg_mode_t'({clamp_en, roll_en});

  // Invert the raw angle for counter-clockwise, then subtract the pre-offset.
  assign pol_angle = polarity ? 12'(12'h000 - raw_angle_i) : raw_angle_i;
  assign pre_angle = 12'(pol_angle - pregain_offset_i);

  // Gain stage, active only with short stroke.
  // With short stroke off the stage passes the angle through untouched, so
  // the zero shift and clamps still apply to the plain offset angle.
  apcfg_gain u_gain (
    .angle_i  (pre_angle),
    .gain_i   (gain_config_i[`APCFG_GAIN_HI:`APCFG_GAIN_LO]),
    .enable_i (ss_en),
    .scaled_o (scaled)
  );

  // Zero shift after gain; the 12-bit sum wraps naturally.
  // A negative shift is stored in two's complement, so a plain 12-bit add
  // subtracts it; no sign extension is needed because the sum wraps anyway.
  assign shifted = 12'(scaled + zero_shift);

  ////////////////////////////////////////////////////////////////////////////
  // Output shaping by clamp and roll-over mode.
  // Mode 00 passes the shifted angle. Mode 01 wraps past one clamp onto the
  // other. Mode 11 saturates at either clamp on every sample. Mode 10 also
  // saturates, but then freezes at the first clamp reached until the mode
  // changes or reset is applied.
  // A low clamp set above the high clamp is not guarded against: the high
  // comparison is tested first and wins.
  always_comb begin
    final_angle = shifted;
    case (mode)
      APCFG_MODE_NORMAL: begin
        final_angle = shifted;
      end
      APCFG_MODE_ROLL: begin
        // Roll over within the clamp window.
        if (shifted > high_clamp) begin
          final_angle = low_clamp;
        end else if (shifted < low_clamp) begin
          final_angle = high_clamp;
        end else begin
          final_angle = shifted;
        end
      end
      APCFG_MODE_CLAMP: begin
        if (state_reg.held) begin
          final_angle = state_reg.held_val;
        end else if (shifted > high_clamp) begin
          final_angle = high_clamp;
        end else if (shifted < low_clamp) begin
          final_angle = low_clamp;
        end else begin
          final_angle = shifted;
        end
      end
      APCFG_MODE_BOTH: begin
        if (shifted > high_clamp) begin
          final_angle = high_clamp;
        end else if (shifted < low_clamp) begin
          final_angle = low_clamp;
        end else begin
          final_angle = shifted;
        end
      end
      default: begin
        final_angle = shifted;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  // The valid strobe is copied every cycle, so the answer stands one cycle.
  // Angle and violation flags change only on a strobe and otherwise keep their value.
  // The held flag is cleared on any cycle outside mode 10, even without a
  // strobe, so a mode change ends the freeze at the next edge; the output angle itself changes only on the next strobe.
  always_comb begin
    state_next       = state_reg;
    state_next.valid = raw_valid_i;
    state_next.bw    = output_shaping_config_i[`APCFG_BW_BIT];
    if (mode != APCFG_MODE_CLAMP) begin
      state_next.held = 1'b0;
    end
    if (raw_valid_i) begin
      state_next.angle = final_angle;
      // Low check: short stroke on and a nonzero limit.
      state_next.min_viol = ss_en && (min_in != `APCFG_MIN_OFF) &&
                            (pre_angle < min_in);
      state_next.max_viol = ss_en && (max_in != `APCFG_MAX_OFF) && (pre_angle > max_in);
      // Latch the first clamp reached and keep it.
      if (mode == APCFG_MODE_CLAMP && !state_reg.held &&
          (shifted > high_clamp || shifted < low_clamp)) begin
        state_next.held     = 1'b1;
        state_next.held_val = final_angle;
      end
    end
  end

  // State register.
  // Reset clears every field, including a frozen clamp value.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register.
  // No logic sits between these flip-flops and the pins.
  assign out_angle_o        = state_reg.angle;
  assign out_valid_o        = state_reg.valid;
  assign min_violation_o    = state_reg.min_viol;
  assign max_violation_o    = state_reg.max_viol;
  assign filter_bw_select_o = state_reg.bw;
endmodule

// *** dv/apcfg_front_model.sv ***
// Front-end model: presents one angle per request with a one-cycle strobe.
// Assumes requests are driven just after the rising edge.
`timescale 1ns/1ps
module apcfg_front_model (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Requests from the bench.
  input  wire logic        req_i,
  input  wire logic [11:0] angle_i,
  // Angle toward the block.
  output logic      [11:0] angle_o,
  output logic             valid_o
);
  // Between strobes the bus toggles, so a stale angle can never pass as fresh.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      angle_o <= 12'h000;
      valid_o <= 1'b0;
    end else begin
      valid_o <= req_i;
      angle_o <= req_i ? angle_i : ~angle_o;
    end
  end
endmodule

// *** dv/apcfg_top_sva.sv ***
// Checker for the angle post-processing stage, bound to its top module.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
module apcfg_top_sva
  import apcfg_pkg::*;
(
  // Clock and reset.
  input wire logic                    ref_clk_i,
  input wire logic                    rstn_i,
  // Inputs of the block.
  input wire apcfg_pkg::apcfg_cfg_t   output_shaping_config_i,
  input wire apcfg_pkg::apcfg_cfg_t   limit_config_i,
  input wire apcfg_pkg::apcfg_cfg_t   gain_config_i,
  input wire apcfg_pkg::apcfg_angle_t pregain_offset_i,
  input wire apcfg_pkg::apcfg_angle_t raw_angle_i,
  input wire logic                    raw_valid_i,
  // Outputs of the block.
  input wire apcfg_pkg::apcfg_angle_t out_angle_o,
  input wire logic                    out_valid_o,
  input wire logic                    min_violation_o,
  input wire logic                    max_violation_o,
  input wire logic                    filter_bw_select_o
);
  apcfg_angle_t exp_q;
  apcfg_angle_t hi_q;
  apcfg_angle_t lo_q;
  // Unscaled angle and clamp levels for the current inputs.
  assign exp_q = apcfg_angle_t'((output_shaping_config_i[24] ? 12'h000 - raw_angle_i : raw_angle_i)
                 - pregain_offset_i + output_shaping_config_i[23:12]);
  assign hi_q = 12'hfff - output_shaping_config_i[11:6] * 12'h029;
  assign lo_q = output_shaping_config_i[5:0] * 12'h029;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_lat; out_valid_o == $past(raw_valid_i); endproperty
  a_lat: assert property (p_lat) else $error("answer strobe not one cycle after request");
  property p_bw; $past(rstn_i) |-> filter_bw_select_o == $past(output_shaping_config_i[25]); endproperty
  a_bw: assert property (p_bw) else $error("filter select not following its bit");
  property p_min_off; raw_valid_i && limit_config_i[11:0] == 12'h000 |=> !min_violation_o; endproperty
  a_min_off: assert property (p_min_off) else $error("low flag with zero limit");
  property p_max_off; raw_valid_i && limit_config_i[23:12] == 12'hfff |=> !max_violation_o; endproperty
  a_max_off: assert property (p_max_off) else $error("high flag with limit disabled");
  property p_ss_off; raw_valid_i && !gain_config_i[25] |=> !(min_violation_o || max_violation_o); endproperty
  a_ss_off: assert property (p_ss_off) else $error("flag without short stroke");
  property p_hold; !raw_valid_i |=> $stable(out_angle_o) && $stable(min_violation_o); endproperty
  a_hold: assert property (p_hold) else $error("output moved without a request");
  property p_direct; raw_valid_i && !gain_config_i[25] && limit_config_i[25:24] == 2'b00
    |=> out_angle_o == $past(exp_q); endproperty
  a_direct: assert property (p_direct) else $error("unscaled angle wrong");
  property p_clamp; raw_valid_i && limit_config_i[25:24] == 2'b11
    |=> out_angle_o <= $past(hi_q) && out_angle_o >= $past(lo_q); endproperty
  a_clamp: assert property (p_clamp) else $error("output outside clamps");
endmodule
bind apcfg_top apcfg_top_sva apcfg_top_sva_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
  .output_shaping_config_i(output_shaping_config_i), .limit_config_i(limit_config_i),
  .gain_config_i(gain_config_i), .pregain_offset_i(pregain_offset_i),
  .raw_angle_i(raw_angle_i), .raw_valid_i(raw_valid_i), .out_angle_o(out_angle_o),
  .out_valid_o(out_valid_o), .min_violation_o(min_violation_o),
  .max_violation_o(max_violation_o), .filter_bw_select_o(filter_bw_select_o));

// *** dv/apcfg_top_test.sv ***
// Self-checking bench: random configs and angles, scoreboard on each answer.
// Assumes configs change only while no angle is in flight.
`timescale 1ns/1ps
module apcfg_top_test;
  import apcfg_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  apcfg_cfg_t osc = '0, lim = '0, gcf = '0;
  apcfg_angle_t pre = '0, ang = '0, raw, out;
  logic req = 1'b0, rv, ov, mnv, mxv, bw;
  int err_total = 0;
  int compares = 0;
  int seed = 70;
  logic [13:0] expq[$];
  // Frozen clamp of the reference model in mode 10.
  logic held_b = 1'b0;
  apcfg_angle_t held_v = '0;
  // Clock of 20 ns period.
  initial forever #10 ref_clk_i = ~ref_clk_i;
  apcfg_front_model apcfg_front_model_inst (.clk_i(ref_clk_i), .rstn_i(rstn_i), .req_i(req),
    .angle_i(ang), .angle_o(raw), .valid_o(rv));
  apcfg_top apcfg_top_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .output_shaping_config_i(osc), .limit_config_i(lim), .gain_config_i(gcf),
    .pregain_offset_i(pre), .raw_angle_i(raw), .raw_valid_i(rv), .out_angle_o(out),
    .out_valid_o(ov), .min_violation_o(mnv), .max_violation_o(mxv), .filter_bw_select_o(bw));
  task automatic check(input string name, input logic [13:0] seen, input logic [13:0] want);
    compares++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, want, seen);
    end
  endtask
  // Flags and output angle the block should give for one input angle.
  function automatic logic [13:0] expect_out(input apcfg_angle_t a);
    logic [11:0] q, t, hi, lo;
    logic [25:0] s;
    q = (osc[24] ? 12'h000 - a : a) - pre;
    s = gcf[25] ? (q * (26'h100 + gcf[12:0])) >> 8 : q;
    if (s > 26'hfff) s = 26'hfff;
    t = s[11:0] + osc[23:12];
    hi = 12'hfff - osc[11:6] * 12'h029;
    lo = osc[5:0] * 12'h029;
    if (lim[25:24] == 2'b01) t = t > hi ? lo : (t < lo ? hi : t);
    if (lim[25:24] == 2'b11) t = t > hi ? hi : (t < lo ? lo : t);
    if (lim[25:24] != 2'b10) held_b = 1'b0;
    else if (held_b) t = held_v;
    else if (t > hi || t < lo) begin
      t = t > hi ? hi : lo;
      held_b = 1'b1;
      held_v = t;
    end
    return {gcf[25] && lim[11:0] != 0 && q < lim[11:0], gcf[25] && lim[23:12] != 12'hfff
            && q > lim[23:12], t};
  endfunction
  // Scoreboard: pop on each answer, then queue the angle taken at this edge.
  always @(posedge ref_clk_i) begin
    if (rstn_i !== 1'b1) held_b = 1'b0;
    if (ov === 1'b1) check("angle", {mnv, mxv, out}, expq.pop_front());
    if (ov === 1'b1) check("filter_bw", 14'(bw), 14'(osc[25]));
    if (rv === 1'b1) expq.push_back(expect_out(raw));
  end
  task automatic end_of_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog well beyond the expected run time.
  initial begin
    #400000;
    err_total++;
    end_of_test();
  end
  // Rounds of random config, each opened by angles on both limit edges.
  initial begin
    apcfg_cfg_t l, o, g;
    apcfg_angle_t p, a;
    repeat (10) @(posedge ref_clk_i);
    check("rst_out", {mnv, mxv, out}, 14'h0000);
    check("rst_strobes", 14'({ov, bw}), 14'h0000);
    rstn_i <= 1'b1;
    for (int r = 0; r < 60; r++) begin
      // A second reset in mid-run must clear outputs and any frozen clamp.
      if (r == 30) begin
        rstn_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        check("rst_out", {mnv, mxv, out}, 14'h0000);
        check("rst_strobes", 14'({ov, bw}), 14'h0000);
        rstn_i <= 1'b1;
      end
      o = r == 0 ? '0 : 26'($random(seed));
      l = r == 0 ? '0 : 26'($random(seed));
      g = 26'($random(seed));
      p = r % 2 ? 12'($random(seed)) : 12'h000;
      o[5:4] = 2'b00;
      g[12:9] = 4'h0;
      if (r % 4 == 1) l[11:0] = 12'h000;
      if (r % 5 == 2) l[23:12] = 12'hfff;
      osc <= o;
      lim <= l;
      gcf <= g;
      pre <= p;
      @(posedge ref_clk_i);
      for (int k = 0; k < 10; k++) begin
        // The first four angles land the compared angle on both limit edges.
        case (k)
          0: a = l[11:0] - 12'h001;
          1: a = l[11:0];
          2: a = l[23:12];
          3: a = l[23:12] + 12'h001;
          default: a = 12'($random(seed));
        endcase
        if (k < 4) a = o[24] ? 12'h000 - (a + p) : a + p;
        req <= 1'b1;
        ang <= a;
        @(posedge ref_clk_i);
        if ($random(seed) & 1) begin
          req <= 1'b0;
          @(posedge ref_clk_i);
        end
      end
      req <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
    end
    check("left", 14'(expq.size()), 14'h0000);
    end_of_test();
  end
endmodule
